/* common/cupc_pkg.sv */
// constants, types and structs of the configuration unit pin control block
package cupc_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] CUPC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] CUPC_ADDR_DATA = 8'h04;
    localparam logic [7:0] CUPC_ADDR_CHECK = 8'h08;
    localparam logic [7:0] CUPC_ADDR_STATUS = 8'h0C;
    localparam int CUPC_CTRL_START_FULL = 0;
    localparam int CUPC_CTRL_START_PART = 1;
    localparam int CUPC_CTRL_FINISH = 2;
    localparam int CUPC_ST_READY = 0;
    localparam int CUPC_ST_DONE = 1;
    localparam int CUPC_ST_PART_HOLD = 2;
    localparam int CUPC_ST_USER = 3;
    localparam int CUPC_ST_ERR_LSB = 4;
    localparam int CUPC_ST_MODE_LSB = 8;
    localparam int CUPC_ST_STRAP_LSB = 12;
    localparam int CUPC_ST_LOADING = 15;
    localparam int CUPC_ERR_CRC = 0;
    localparam int CUPC_ERR_OVERFLOW = 1;
    localparam int CUPC_ERR_SEQUENCE = 2;
    // ----------------------------------------
    // test port and mode codes
    // ----------------------------------------
    localparam int CUPC_TCK_MAX_MHZ = 50;
    localparam logic [3:0] CUPC_IR_IDCODE = 4'h1;
    localparam logic [3:0] CUPC_IR_CFG_IN = 4'h2;
    localparam logic [3:0] CUPC_IR_BYPASS = 4'hF;
    localparam logic [3:0] CUPC_IR_CAPTURE = 4'h1;
    localparam logic [3:0] CUPC_MODE_JTAG = 4'h0;
    localparam logic [31:0] CUPC_RST_CHECKSUM = 32'h0000_0000;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [15:0] {
        CUPC_TLR = 16'h0001, CUPC_RTI = 16'h0002, CUPC_SEL_DR = 16'h0004, CUPC_CAP_DR = 16'h0008,
        CUPC_SHIFT_DR = 16'h0010, CUPC_EXIT1_DR = 16'h0020, CUPC_PAUSE_DR = 16'h0040,
        CUPC_EXIT2_DR = 16'h0080, CUPC_UPD_DR = 16'h0100, CUPC_SEL_IR = 16'h0200,
        CUPC_CAP_IR = 16'h0400, CUPC_SHIFT_IR = 16'h0800, CUPC_EXIT1_IR = 16'h1000,
        CUPC_PAUSE_IR = 16'h2000, CUPC_EXIT2_IR = 16'h4000, CUPC_UPD_IR = 16'h8000
    } cupc_tap_e;
    typedef enum logic [6:0] {
        CUPC_INIT = 7'h01, CUPC_CLEAR = 7'h02, CUPC_READY = 7'h04, CUPC_LOAD = 7'h08,
        CUPC_DONE = 7'h10, CUPC_USER = 7'h20, CUPC_ERROR = 7'h40
    } cupc_cfg_e;
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } cupc_jtag_s;
    typedef struct packed {
        logic tdo_in;
        logic tdo_out;
        logic tdo_oe;
    } cupc_tdo_s;
endpackage : cupc_pkg

/* logic/cupc_top.sv */
// configuration unit pin control: test port, loader, status pins and register slave
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module cupc_top #(
    parameter int MEM_DEPTH = 8,
    parameter logic [31:0] IDCODE_VALUE = 32'h1234_5001  // arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cupc_pkg::cupc_jtag_s jtag_pins,
    output logic tdo_out,
    output logic tdo_oe,
    input wire cupc_pkg::cupc_jtag_s xcvr_unused_in,
    output cupc_pkg::cupc_jtag_s xcvr_jtag,
    input wire logic xcvr_tdo,
    input wire logic xcvr_tdo_oe,
    input wire logic host_clk,
    input wire logic cfg_clock_select,
    input wire logic clear_skip_in,
    input wire logic [3:0] load_mode_select,
    input wire logic [2:0] test_strap,
    input wire logic transceiver_jtag_route,
    input wire logic host_select_n,
    input wire logic test_host_select_n,
    input wire logic load_reset_n,
    output logic [2:0] load_error_code,
    input wire logic load_complete_in,
    output logic load_complete_out,
    output logic load_complete_oe,
    input wire logic partial_load_complete_in,
    output logic partial_load_complete_out,
    output logic partial_load_complete_oe,
    input wire logic load_ready_status_in,
    output logic load_ready_status_out,
    output logic load_ready_status_oe,
    output logic user_mode
);
    import cupc_pkg::*;

    if (MEM_DEPTH < 2 || MEM_DEPTH > 256) begin : g_bad_depth
        $error("MEM_DEPTH out of range");
    end

    localparam int IW = $clog2(MEM_DEPTH);

    // ----------------------------------------
    // input synchronisers and edge finding
    // ----------------------------------------
    logic [20:0] sync1;
    logic [20:0] sync2;
    logic tck_q;
    logic hclk_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
            tck_q <= 1'b0;
            hclk_q <= 1'b0;
        end else begin
            sync1 <= {jtag_pins.tck, jtag_pins.tms, jtag_pins.tdi, jtag_pins.trst_n, host_clk,
                      cfg_clock_select, clear_skip_in, transceiver_jtag_route, host_select_n,
                      test_host_select_n, load_complete_in, partial_load_complete_in,
                      xcvr_tdo, xcvr_tdo_oe, load_mode_select, test_strap};
            sync2 <= sync1;
            tck_q <= sync2[20];
            hclk_q <= sync2[16];
        end
    end
    logic s_tck, s_tms, s_tdi, s_trst_n, s_hclk, s_clk_sel, s_skip, s_route;
    logic s_hsel_n, s_thsel_n, s_done_in, s_part_in, s_xtdo, s_xtdo_oe;
    logic [3:0] s_mode;
    logic [2:0] s_strap;
    assign {s_tck, s_tms, s_tdi, s_trst_n, s_hclk, s_clk_sel, s_skip, s_route, s_hsel_n, s_thsel_n,
            s_done_in, s_part_in, s_xtdo, s_xtdo_oe, s_mode, s_strap} = sync2;
    logic tck_rise;
    logic tck_fall;
    logic cfg_tick;
    assign tck_rise = s_tck & ~tck_q;
    assign tck_fall = ~s_tck & tck_q;
    assign cfg_tick = s_clk_sel ? (s_hclk & ~hclk_q) : tck_rise;

    // ----------------------------------------
    // test access port controller
    // ----------------------------------------
    function automatic cupc_tap_e tap_next(input cupc_tap_e st, input logic tms);
        case (st)
            CUPC_TLR: tap_next = tms ? CUPC_TLR : CUPC_RTI;
            CUPC_RTI: tap_next = tms ? CUPC_SEL_DR : CUPC_RTI;
            CUPC_SEL_DR: tap_next = tms ? CUPC_SEL_IR : CUPC_CAP_DR;
            CUPC_CAP_DR: tap_next = tms ? CUPC_EXIT1_DR : CUPC_SHIFT_DR;
            CUPC_SHIFT_DR: tap_next = tms ? CUPC_EXIT1_DR : CUPC_SHIFT_DR;
            CUPC_EXIT1_DR: tap_next = tms ? CUPC_UPD_DR : CUPC_PAUSE_DR;
            CUPC_PAUSE_DR: tap_next = tms ? CUPC_EXIT2_DR : CUPC_PAUSE_DR;
            CUPC_EXIT2_DR: tap_next = tms ? CUPC_UPD_DR : CUPC_SHIFT_DR;
            CUPC_UPD_DR: tap_next = tms ? CUPC_SEL_DR : CUPC_RTI;
            CUPC_SEL_IR: tap_next = tms ? CUPC_TLR : CUPC_CAP_IR;
            CUPC_CAP_IR: tap_next = tms ? CUPC_EXIT1_IR : CUPC_SHIFT_IR;
            CUPC_SHIFT_IR: tap_next = tms ? CUPC_EXIT1_IR : CUPC_SHIFT_IR;
            CUPC_EXIT1_IR: tap_next = tms ? CUPC_UPD_IR : CUPC_PAUSE_IR;
            CUPC_PAUSE_IR: tap_next = tms ? CUPC_EXIT2_IR : CUPC_PAUSE_IR;
            CUPC_EXIT2_IR: tap_next = tms ? CUPC_UPD_IR : CUPC_SHIFT_IR;
            CUPC_UPD_IR: tap_next = tms ? CUPC_SEL_DR : CUPC_RTI;
            default: tap_next = CUPC_TLR;
        endcase
    endfunction : tap_next

    cupc_tap_e tap;
    logic [3:0] ir;
    logic [3:0] ir_shift;
    logic [31:0] dr_shift;
    logic jtag_word_valid;
    logic [31:0] jtag_word;
    logic tap_hold;
    assign tap_hold = ~s_trst_n | s_route;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap <= CUPC_TLR;
        end else if (tap_hold) begin
            tap <= CUPC_TLR;
        end else if (tck_rise) begin
            tap <= tap_next(tap, s_tms);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir <= CUPC_IR_IDCODE;
            ir_shift <= '0;
            dr_shift <= '0;
            jtag_word_valid <= 1'b0;
            jtag_word <= '0;
        end else begin
            jtag_word_valid <= 1'b0;
            if (tap_hold || (tck_rise && tap == CUPC_TLR)) begin
                ir <= CUPC_IR_IDCODE;
            end else if (tck_rise) begin
                case (tap)
                    CUPC_CAP_IR: ir_shift <= CUPC_IR_CAPTURE;
                    CUPC_SHIFT_IR: ir_shift <= {s_tdi, ir_shift[3:1]};
                    CUPC_UPD_IR: ir <= ir_shift;
                    CUPC_CAP_DR: dr_shift <= (ir == CUPC_IR_IDCODE) ? IDCODE_VALUE : '0;
                    CUPC_SHIFT_DR: begin
                        if (ir == CUPC_IR_IDCODE || ir == CUPC_IR_CFG_IN) begin
                            dr_shift <= {s_tdi, dr_shift[31:1]};
                        end else begin
                            dr_shift[0] <= s_tdi;
                        end
                    end
                    CUPC_UPD_DR: begin
                        if (ir == CUPC_IR_CFG_IN) begin
                            jtag_word_valid <= 1'b1;
                            jtag_word <= dr_shift;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // test data output, moved on falling test clock edges, or copied from the transceiver every cycle when routed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdo_out <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (s_route) begin
            tdo_out <= s_xtdo;
            tdo_oe <= s_xtdo_oe;
        end else if (!s_trst_n) begin
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_out <= (tap == CUPC_SHIFT_IR) ? ir_shift[0] : dr_shift[0];
            tdo_oe <= (tap == CUPC_SHIFT_IR) || (tap == CUPC_SHIFT_DR);
        end
    end

    // transceiver test controller path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xcvr_jtag <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b0};
        end else if (s_route) begin
            xcvr_jtag <= '{tck: s_tck, tms: s_tms, tdi: s_tdi, trst_n: s_trst_n};
        end else begin
            xcvr_jtag <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b0};
        end
    end

    // ----------------------------------------
    // configuration reset
    // ----------------------------------------
    logic cfg_arst_n;
    logic [1:0] cfg_rst_sync;
    logic cfg_rst_n;
    assign cfg_arst_n = presetn & load_reset_n;
    assign cfg_rst_n = cfg_rst_sync[1];
    always_ff @(posedge pclk or negedge cfg_arst_n) begin
        if (!cfg_arst_n) begin
            cfg_rst_sync <= 2'b00;
        end else begin
            cfg_rst_sync <= {cfg_rst_sync[0], 1'b1};
        end
    end

    // ----------------------------------------
    // register slave
    // ----------------------------------------
    logic acc_wr;
    logic wr_ctrl;
    logic wr_data;
    logic wr_check;
    logic [31:0] status_word;
    logic [31:0] next_prdata;
    logic next_pslverr;
    assign acc_wr = psel & penable & pready & pwrite;
    assign wr_ctrl = acc_wr && paddr == CUPC_ADDR_CTRL;
    assign wr_data = acc_wr && paddr == CUPC_ADDR_DATA;
    assign wr_check = acc_wr && paddr == CUPC_ADDR_CHECK;

    always_comb begin
        next_prdata = '0;
        next_pslverr = 1'b0;
        if (paddr == CUPC_ADDR_STATUS) begin
            next_prdata = pwrite ? '0 : status_word;
            next_pslverr = pwrite;
        end else if (paddr == CUPC_ADDR_CTRL || paddr == CUPC_ADDR_DATA || paddr == CUPC_ADDR_CHECK) begin
            next_pslverr = 1'b0;
        end else begin
            next_pslverr = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            prdata <= (psel & ~penable) ? next_prdata : '0;
            pslverr <= (psel & ~penable) ? next_pslverr : 1'b0;
        end
    end

    // ----------------------------------------
    // configuration unit
    // ----------------------------------------
    cupc_cfg_e cfg;
    logic [3:0] mode;
    logic [2:0] strap;
    logic partial_mode;
    logic [IW:0] word_count;
    logic [IW-1:0] clear_idx;
    logic [31:0] checksum;
    logic [31:0] expect_sum;
    logic [31:0] mem [MEM_DEPTH];
    logic host_sel_n;
    logic word_in;
    logic [31:0] word_val;
    logic finish;
    logic sum_ok;

    assign host_sel_n = strap[0] ? s_thsel_n : s_hsel_n;
    assign word_in = (cfg == CUPC_LOAD) && ((mode == CUPC_MODE_JTAG) ? jtag_word_valid
                                                                      : (wr_data && !host_sel_n));
    assign word_val = (mode == CUPC_MODE_JTAG) ? jtag_word : pwdata;
    assign finish = wr_ctrl && pwdata[CUPC_CTRL_FINISH] && cfg == CUPC_LOAD;
    assign sum_ok = checksum == expect_sum;

    always_ff @(posedge pclk or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            cfg <= CUPC_INIT;
            mode <= '0;
            strap <= '0;
            partial_mode <= 1'b0;
            word_count <= '0;
            clear_idx <= '0;
            checksum <= CUPC_RST_CHECKSUM;
            expect_sum <= CUPC_RST_CHECKSUM;
            load_error_code <= '0;
            load_complete_oe <= 1'b1;
            partial_load_complete_oe <= 1'b0;
            load_ready_status_oe <= 1'b1;
            user_mode <= 1'b0;
        end else begin
            if (wr_check) begin
                expect_sum <= pwdata;
            end
            case (cfg)
                CUPC_INIT: begin
                    mode <= s_mode;
                    strap <= s_strap;
                    clear_idx <= '0;
                    cfg <= s_skip ? CUPC_READY : CUPC_CLEAR;
                end
                CUPC_CLEAR: begin
                    if (cfg_tick) begin
                        clear_idx <= clear_idx + 1'b1;
                        if (clear_idx == IW'(MEM_DEPTH - 1)) begin
                            cfg <= CUPC_READY;
                        end
                    end
                end
                CUPC_READY, CUPC_DONE, CUPC_USER: begin
                    load_ready_status_oe <= 1'b0;
                    if (cfg == CUPC_DONE && cfg_tick && s_done_in && s_part_in) begin
                        cfg <= CUPC_USER;
                        user_mode <= 1'b1;
                    end
                    if (wr_ctrl && pwdata[CUPC_CTRL_START_FULL] && cfg == CUPC_READY) begin
                        cfg <= CUPC_LOAD;
                        partial_mode <= 1'b0;
                        word_count <= '0;
                        checksum <= CUPC_RST_CHECKSUM;
                    end else if (wr_ctrl && pwdata[CUPC_CTRL_START_PART] && cfg != CUPC_READY) begin
                        cfg <= CUPC_LOAD;
                        partial_mode <= 1'b1;
                        partial_load_complete_oe <= 1'b1;
                        word_count <= '0;
                        checksum <= CUPC_RST_CHECKSUM;
                    end
                end
                CUPC_LOAD: begin
                    if (word_in) begin
                        if (word_count == (IW+1)'(MEM_DEPTH)) begin
                            load_error_code[CUPC_ERR_OVERFLOW] <= 1'b1;
                            cfg <= CUPC_ERROR;
                        end else begin
                            word_count <= word_count + 1'b1;
                            checksum <= {checksum[30:0], checksum[31]} ^ word_val;
                        end
                    end else if (finish) begin
                        if (word_count == '0) begin
                            load_error_code[CUPC_ERR_SEQUENCE] <= 1'b1;
                            cfg <= CUPC_ERROR;
                        end else if (!sum_ok) begin
                            load_error_code[CUPC_ERR_CRC] <= 1'b1;
                            load_ready_status_oe <= 1'b1;
                            cfg <= CUPC_ERROR;
                        end else begin
                            cfg <= CUPC_DONE;
                            if (partial_mode) begin
                                partial_load_complete_oe <= 1'b0;
                            end else begin
                                load_complete_oe <= 1'b0;
                            end
                        end
                    end
                end
                CUPC_ERROR: begin
                    cfg <= CUPC_ERROR;
                    user_mode <= 1'b0;
                end
                default: cfg <= CUPC_INIT;
            endcase
        end
    end

    // configuration memory, cleared by reset and by the clearing step
    always_ff @(posedge pclk or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (cfg == CUPC_CLEAR && cfg_tick) begin
            mem[clear_idx] <= '0;
        end else if (word_in && word_count < (IW+1)'(MEM_DEPTH)) begin
            mem[word_count[IW-1:0]] <= word_val;
        end
    end

    // open-drain lines drive low only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_complete_out <= 1'b0;
            partial_load_complete_out <= 1'b0;
            load_ready_status_out <= 1'b0;
        end else begin
            load_complete_out <= 1'b0;
            partial_load_complete_out <= 1'b0;
            load_ready_status_out <= 1'b0;
        end
    end

    always_comb begin
        status_word = '0;
        status_word[CUPC_ST_READY] = ~load_ready_status_oe;
        status_word[CUPC_ST_DONE] = ~load_complete_oe;
        status_word[CUPC_ST_PART_HOLD] = partial_load_complete_oe;
        status_word[CUPC_ST_USER] = user_mode;
        status_word[CUPC_ST_ERR_LSB +: 3] = load_error_code;
        status_word[CUPC_ST_MODE_LSB +: 4] = mode;
        status_word[CUPC_ST_STRAP_LSB +: 3] = strap;
        status_word[CUPC_ST_LOADING] = cfg == CUPC_LOAD;
    end
endmodule : cupc_top

/* dv/cupc_asserts.sv */
// checker of the config unit pin rules
`timescale 1ns/10ps
module cupc_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load_reset_n,
    input wire logic [2:0] load_error_code,
    input wire logic load_complete_in,
    input wire logic load_complete_oe,
    input wire logic partial_load_complete_in,
    input wire logic load_ready_status_oe,
    input wire logic user_mode,
    input wire logic tdo_oe,
    input wire cupc_pkg::cupc_jtag_s jtag_pins,
    input wire logic transceiver_jtag_route,
    input wire logic xcvr_tdo_oe
);
    import cupc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn || !load_reset_n);
    // ----------------
    // assertions
    // ----------------
    a_err_sticky: assert property (|load_error_code |=> ($past(load_error_code) & ~load_error_code) == 3'h0)
        else $error("error bit fell");
    a_err_blocks: assert property (|load_error_code && load_complete_oe |=> load_complete_oe && !user_mode)
        else $error("load done despite error");
    a_user_lines: assert property ($rose(user_mode) |-> $past(load_complete_in, 3) && $past(partial_load_complete_in, 3))
        else $error("user mode with low lines");
    a_user_freed: assert property (user_mode |-> !load_complete_oe)
        else $error("user mode while done low");
    a_done_hold: assert property (!load_complete_oe |=> !load_complete_oe)
        else $error("done line pulled again");
    a_ready_hold: assert property (!load_ready_status_oe && load_error_code == 3'h0 |=> !load_ready_status_oe || |load_error_code)
        else $error("ready dropped");
    a_tdo_float: assert property ((!transceiver_jtag_route && !jtag_pins.trst_n) [*4] |-> !tdo_oe)
        else $error("tdo driven in reset");
    a_route_tdo: assert property ((transceiver_jtag_route && $stable(xcvr_tdo_oe)) [*4] |-> tdo_oe == xcvr_tdo_oe)
        else $error("route tdo enable");
    c_user: cover property ($rose(user_mode));
    c_err: cover property ($rose(|load_error_code));
    c_scan: cover property ($rose(tdo_oe));
endmodule : cupc_asserts
bind cupc_top cupc_asserts chk_u (.pclk(pclk), .presetn(presetn), .load_reset_n(load_reset_n),
    .load_error_code(load_error_code), .load_complete_in(load_complete_in), .load_complete_oe(load_complete_oe),
    .partial_load_complete_in(partial_load_complete_in), .load_ready_status_oe(load_ready_status_oe),
    .user_mode(user_mode), .tdo_oe(tdo_oe), .jtag_pins(jtag_pins),
    .transceiver_jtag_route(transceiver_jtag_route), .xcvr_tdo_oe(xcvr_tdo_oe));

/* dv/cupc_jtag_host.sv */
// jtag test host model driving the test port pins
`timescale 1ns/10ps
module cupc_jtag_host (
    input wire logic pclk,
    input wire logic tdo_out,
    input wire logic tdo_oe,
    output cupc_pkg::cupc_jtag_s pins
);
    import cupc_pkg::*;
    logic last = 1'b0;
    logic tdo_w;
    always @(posedge pclk) begin
        if (tdo_oe) last <= tdo_out;
    end
    assign tdo_w = tdo_oe ? tdo_out : ~last;
    initial pins = 4'b0100;
    // one tck period of 8 pclk cycles, tck still between frames
    task automatic step(input logic ms, input logic di, output logic q);
        pins.tms <= ms;
        pins.tdi <= di;
        repeat (4) @(posedge pclk);
        q = tdo_w;
        pins.tck <= 1'b1;
        repeat (4) @(posedge pclk);
        pins.tck <= 1'b0;
    endtask : step
    task automatic trst();
        pins.trst_n <= 1'b0;
        repeat (6) @(posedge pclk);
        pins.trst_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : trst
    task automatic read_id(input logic [31:0] d, output logic [63:0] v);
        logic q;
        for (int i = 0; i < 70; i++) begin
            step(i == 1 || i == 67 || i == 68, i > 3 && i < 36 && d[(i + 28) % 32], q);
            if (i > 3 && i < 68) v[i - 4] = q;
        end
    endtask : read_id
    task automatic load_word(input logic [31:0] d);
        logic q;
        for (int i = 0; i < 47; i++) begin
            step(i == 1 || i == 2 || (i > 7 && i < 11) || i > 43 && i < 46,
                 i > 4 && i < 9 ? CUPC_IR_CFG_IN[i - 5] : i > 12 && i < 45 && d[i - 13], q);
        end
    endtask : load_word
endmodule : cupc_jtag_host

/* dv/tb.sv */
// self-checking bench of the config unit pin control block
`timescale 1ns/10ps
module tb;
    import cupc_pkg::*;
    localparam logic [31:0] ID = 32'h5A5A_C3C3; // arbitrary value
    logic pclk, presetn, psel, penable, pwrite, host_clk, cs, sk, hold, route, xoe, xtdo, lrn;
    logic pready, pslverr, er, tdo_out, tdo_oe, lc_oe, plc_oe, rdy_oe, user_mode;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, w;
    logic [31:0] seed = 32'hB869EA6A;
    logic [63:0] v;
    logic [3:0] mode;
    logic [2:0] strap, err;
    cupc_jtag_s pins, xj;
    int n_fail = 0;
    int n_checks = 0;
    int t0, t1;
    cupc_top #(.MEM_DEPTH(8), .IDCODE_VALUE(ID)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .jtag_pins(pins), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .xcvr_unused_in(4'h0),
        .xcvr_jtag(xj), .xcvr_tdo(xtdo), .xcvr_tdo_oe(xoe), .host_clk(host_clk), .cfg_clock_select(cs),
        .clear_skip_in(sk), .load_mode_select(mode), .test_strap(strap), .transceiver_jtag_route(route),
        .host_select_n(1'b0), .test_host_select_n(1'b1), .load_reset_n(lrn), .load_error_code(err),
        .load_complete_in(~lc_oe & ~hold), .load_complete_out(), .load_complete_oe(lc_oe),
        .partial_load_complete_in(~plc_oe), .partial_load_complete_out(), .partial_load_complete_oe(plc_oe),
        .load_ready_status_in(~rdy_oe), .load_ready_status_out(), .load_ready_status_oe(rdy_oe),
        .user_mode(user_mode));
    cupc_jtag_host host_u (.pclk(pclk), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .pins(pins));
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        host_clk = 0;
        forever #80 host_clk = ~host_clk;
    end
    // ----------------
    // tasks
    // ----------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // reset the config unit with fresh straps, count cycles until ready
    task automatic rst(input logic c, input logic s, input logic [3:0] m, input logic [2:0] st, output int t);
        @(posedge pclk);
        {lrn, cs, sk, mode, strap} <= {1'b0, c, s, m, st};
        repeat (3) @(posedge pclk);
        lrn <= 1'b1;
        for (t = 0; t < 300 && rdy_oe !== 1'b0; t++) @(posedge pclk);
    endtask : rst
    task automatic load(input int k, input int how);
        logic [31:0] s;
        s = 0;
        apb(1, CUPC_ADDR_CTRL, 32'h1 << k);
        repeat (8) @(posedge pclk);
        repeat (how == 3 ? 9 : 4) begin
            w = rnd();
            s = {s[30:0], s[31]} ^ w;
            if (how == 4) host_u.load_word(w);
            else apb(1, CUPC_ADDR_DATA, w);
        end
        apb(1, CUPC_ADDR_CHECK, how == 2 ? 32'h0 : s ^ (how == 1));
        apb(1, CUPC_ADDR_CTRL, 32'h1 << CUPC_CTRL_FINISH);
        repeat (20) @(posedge pclk);
    endtask : load
    task automatic close_out();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    initial begin
        repeat (40000) @(posedge pclk);
        n_fail++;
        $display("[ERR] %0t watchdog", $time);
        close_out();
    end
    initial begin
        {presetn, psel, penable, pwrite, cs, sk, hold, route, xoe, xtdo, lrn} = 11'h0;
        {paddr, pwdata, mode, strap} = {8'h0, 32'h0, 4'h1, 3'h0};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rst(0, 0, 4'h1, 3'h0, t0);
        chk(t0 == 300 && rdy_oe === 1'b1, "cleared on idle tck");
        rst(1, 0, 4'h1, 3'h0, t0);
        chk(rdy_oe === 1'b0, "ready not raised");
        rst(1, 1, 4'h1, 3'h0, t1);
        chk(t0 < 300 && t1 + 28 <= t0, "clear not skipped");
        $display("test reset done");
        w = rnd();
        host_u.trst();
        host_u.read_id(w, v);
        chk(v === {w, ID} && tdo_oe === 1'b0, "id scan");
        $display("test jtag done");
        apb(0, 8'h10, 32'h0);
        chk(er === 1'b1, "unmapped accepted");
        hold <= 1'b1;
        load(CUPC_CTRL_START_FULL, 0);
        chk(lc_oe === 1'b0 && err === 3'h0, "full load");
        repeat (40) @(posedge pclk);
        chk(user_mode === 1'b0, "user while held");
        hold <= 1'b0;
        for (t0 = 0; t0 < 100 && user_mode !== 1'b1; t0++) @(posedge pclk);
        chk(user_mode === 1'b1, "no user mode");
        load(CUPC_CTRL_START_PART, 0);
        chk(plc_oe === 1'b0 && lc_oe === 1'b0, "partial load");
        apb(0, CUPC_ADDR_STATUS, 32'h0);
        chk(rd[11:8] === 4'h1 && rd[6:4] === 3'h0, "status");
        $display("test load done");
        for (int i = 0; i < 4; i++) begin
            rst(1, 1, {3'h0, i != 0}, {2'h0, i == 1}, t0);
            load(CUPC_CTRL_START_FULL, i < 2 ? 2 : 2 * i - 3);
            chk(err === (i < 2 ? 3'h4 : 3'(i - 1)) && lc_oe === 1'b1 && user_mode === 1'b0,
                "error case");
            chk(rdy_oe === (i == 2), "ready kept");
        end
        rst(1, 1, 4'h0, 3'h0, t0);
        load(CUPC_CTRL_START_FULL, 4);
        chk(lc_oe === 1'b0 && err === 3'h0, "jtag load");
        $display("test errors done");
        {route, xoe, xtdo} <= {2'b11, 1'(rnd() >> 31)};
        repeat (10) @(posedge pclk);
        chk(tdo_oe === 1'b1 && tdo_out === xtdo && xj === pins, "route");
        {route, xoe} <= 2'b00;
        repeat (10) @(posedge pclk);
        $display("test route done");
        close_out();
    end
endmodule : tb
